// ---- verilog/exec_pkg.sv ----
// Constants for the xor, divide and increment execution datapath
package exec_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ACC_A_OFS = 8'h00;
  localparam logic [7:0] ACC_B_OFS = 8'h04;
  localparam logic [7:0] INDEX_X_OFS = 8'h08;
  localparam logic [7:0] CCR_OFS = 8'h0C;
  localparam logic [7:0] OPERAND_OFS = 8'h10;
  localparam logic [7:0] COMMAND_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] MEM_RESULT_OFS = 8'h1C;

  // ------------------------------------------------------------
  // Condition code and status register bit positions
  // ------------------------------------------------------------
  localparam int CCR_N_BIT = 3;
  localparam int CCR_Z_BIT = 2;
  localparam int CCR_V_BIT = 1;
  localparam int CCR_C_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ILLEGAL_BIT = 1;

  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX_Y = 8'h18;
  localparam logic [7:0] OP_XOR_A_IMM = 8'h88;
  localparam logic [7:0] OP_XOR_A_DIR = 8'h98;
  localparam logic [7:0] OP_XOR_A_EXT = 8'hB8;
  localparam logic [7:0] OP_XOR_A_IND = 8'hA8;
  localparam logic [7:0] OP_XOR_B_IMM = 8'hC8;
  localparam logic [7:0] OP_XOR_B_DIR = 8'hD8;
  localparam logic [7:0] OP_XOR_B_EXT = 8'hF8;
  localparam logic [7:0] OP_XOR_B_IND = 8'hE8;
  localparam logic [7:0] OP_FRACTIONAL_DIVIDE = 8'h03;
  localparam logic [7:0] OP_INTEGER_DIVIDE = 8'h02;
  localparam logic [7:0] OP_INC_A = 8'h4C;
  localparam logic [7:0] OP_INC_B = 8'h5C;
  localparam logic [7:0] OP_INC_EXT = 8'h7C;
  localparam logic [7:0] OP_INC_IND = 8'h6C;

  // ------------------------------------------------------------
  // Values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] INC_STEP = 8'h01;
  localparam logic [7:0] INC_OVERFLOW_OPERAND = 8'h7F;
  localparam logic [15:0] DIV_SATURATED = 16'hFFFF;
  localparam logic [15:0] IDLE_READ_ADDR = 16'hFFFF;
  localparam int DIV_FIRST_IDLE_CYCLE = 3;
  localparam int DIV_LAST_IDLE_CYCLE = 41;
  localparam logic [5:0] DIV_IDLE_CYCLES =
    6'(DIV_LAST_IDLE_CYCLE - DIV_FIRST_IDLE_CYCLE + 1);
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0] CCR_RESET = 8'h00;

  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_XOR,
    OPK_FRACTIONAL_DIVIDE,
    OPK_INTEGER_DIVIDE,
    OPK_INC_ACC,
    OPK_INC_MEM
  } op_kind_t;

endpackage : exec_pkg

// ---- verilog/xor_divide_increment_exec.sv ----
// Execution datapath for xor, fractional/integer divide and increment
`timescale 1ns/100ps
module xor_divide_increment_exec (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core memory bus idle reads
  output logic [15:0] mem_addr,
  output logic mem_rd
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] acc_a_reg;
  logic [7:0] acc_b_reg;
  logic [15:0] index_x_register_reg;
  logic [7:0] ccr_reg;
  logic [7:0] operand_reg;
  logic [7:0] mem_result_reg;
  logic illegal_reg;
  logic busy_reg;
  logic fractional_divide_mode_reg;
  logic [5:0] idle_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic bus_req;
  logic wr_en;
  logic cmd_wr;
  logic [7:0] cmd_opcode;
  logic [7:0] cmd_prefix;
  exec_pkg::op_kind_t cmd_kind;
  logic cmd_use_b;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_en = bus_req & wb_we_i & clk_en;
  assign cmd_wr = wr_en & (wb_adr_i == exec_pkg::COMMAND_OFS) &
                  wb_sel_i[0] & ~busy_reg;
  assign cmd_opcode = wb_dat_i[7:0];
  assign cmd_prefix = wb_dat_i[15:8];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Y prefix is legal only ahead of indexed xor and indexed increment
  function automatic exec_pkg::op_kind_t decode_kind(
    input logic [7:0] op,
    input logic [7:0] pre
  );
    exec_pkg::op_kind_t k;
    logic y_ok;
    logic pre_none;
    k = exec_pkg::OPK_NONE;
    pre_none = (pre == 8'h00);
    y_ok = (pre == exec_pkg::OP_PREFIX_Y);
    unique case (op)
      exec_pkg::OP_XOR_A_IMM, exec_pkg::OP_XOR_A_DIR,
      exec_pkg::OP_XOR_A_EXT, exec_pkg::OP_XOR_B_IMM,
      exec_pkg::OP_XOR_B_DIR, exec_pkg::OP_XOR_B_EXT: begin
        k = pre_none ? exec_pkg::OPK_XOR : exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_XOR_A_IND, exec_pkg::OP_XOR_B_IND: begin
        k = (pre_none | y_ok) ? exec_pkg::OPK_XOR :
                                exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_FRACTIONAL_DIVIDE: begin
        k = pre_none ? exec_pkg::OPK_FRACTIONAL_DIVIDE : exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_INTEGER_DIVIDE: begin
        k = pre_none ? exec_pkg::OPK_INTEGER_DIVIDE : exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_INC_A, exec_pkg::OP_INC_B: begin
        k = pre_none ? exec_pkg::OPK_INC_ACC : exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_INC_EXT: begin
        k = pre_none ? exec_pkg::OPK_INC_MEM : exec_pkg::OPK_NONE;
      end
      exec_pkg::OP_INC_IND: begin
        k = (pre_none | y_ok) ? exec_pkg::OPK_INC_MEM :
                                exec_pkg::OPK_NONE;
      end
      default: begin
        k = exec_pkg::OPK_NONE;
      end
    endcase
    return k;
  endfunction : decode_kind

  assign cmd_kind = decode_kind(cmd_opcode, cmd_prefix);
  // Bit 6 of the opcode picks accumulator B for xor; increment needs bits 6 and 4 both set
  assign cmd_use_b = cmd_opcode[6] & cmd_opcode[4] |
                     (cmd_opcode == exec_pkg::OP_XOR_B_IMM) |
                     (cmd_opcode == exec_pkg::OP_XOR_B_IND);

  // ------------------------------------------------------------
  // Single-cycle results
  // ------------------------------------------------------------
  logic [7:0] sel_acc;
  logic [7:0] xor_result;
  logic [7:0] inc_src;
  logic [7:0] inc_result;

  assign sel_acc = cmd_use_b ? acc_b_reg : acc_a_reg;
  assign xor_result = sel_acc ^ operand_reg;
  assign inc_src = (cmd_kind == exec_pkg::OPK_INC_MEM) ? operand_reg : sel_acc;
  assign inc_result = inc_src + exec_pkg::INC_STEP;

  // ------------------------------------------------------------
  // Divide results, taken when the idle reads end
  // ------------------------------------------------------------
  logic [15:0] numer;
  logic [15:0] denom;
  logic denom_zero;
  logic frac_over;
  logic [31:0] frac_num;
  logic [31:0] frac_q_wide;
  logic [31:0] frac_r_wide;
  logic [15:0] div_q;
  logic [15:0] div_r;
  logic [7:0] div_ccr;
  logic div_done;

  assign numer = {acc_a_reg, acc_b_reg};
  assign denom = index_x_register_reg;
  assign denom_zero = (denom == 16'h0000);
  assign frac_over = (denom <= numer);
  assign frac_num = {numer, 16'h0000};
  assign frac_q_wide = denom_zero ? 32'h0000_0000 : frac_num / denom;
  assign frac_r_wide = denom_zero ? 32'h0000_0000 : frac_num % denom;
  assign div_done = busy_reg & (idle_cnt_reg == 6'h01);

  always_comb begin
    div_ccr = ccr_reg;
    if (fractional_divide_mode_reg) begin
      div_q = frac_over ? exec_pkg::DIV_SATURATED : frac_q_wide[15:0];
      div_r = frac_over ? numer : frac_r_wide[15:0];
      div_ccr[exec_pkg::CCR_V_BIT] = frac_over;
    end else begin
      div_q = denom_zero ? exec_pkg::DIV_SATURATED : numer / denom;
      div_r = denom_zero ? numer : numer % denom;
      div_ccr[exec_pkg::CCR_V_BIT] = 1'b0;
    end
    div_ccr[exec_pkg::CCR_Z_BIT] = (div_q == 16'h0000);
    div_ccr[exec_pkg::CCR_C_BIT] = denom_zero;
  end

  // ------------------------------------------------------------
  // Condition codes
  // ------------------------------------------------------------
  function automatic logic [7:0] nzv_update(
    input logic [7:0] condition_code_register,
    input logic [7:0] res,
    input logic v
  );
    logic [7:0] c;
    c = condition_code_register;
    c[exec_pkg::CCR_N_BIT] = res[7];
    c[exec_pkg::CCR_Z_BIT] = (res == 8'h00);
    c[exec_pkg::CCR_V_BIT] = v;
    return c;
  endfunction : nzv_update

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ccr_reg <= exec_pkg::CCR_RESET;
    end else if (clk_en) begin
      if (div_done) begin
        ccr_reg <= div_ccr;
      end else if (cmd_wr && cmd_kind == exec_pkg::OPK_XOR) begin
        ccr_reg <= nzv_update(ccr_reg, xor_result, 1'b0);
      end else if (cmd_wr && (cmd_kind == exec_pkg::OPK_INC_ACC ||
                              cmd_kind == exec_pkg::OPK_INC_MEM)) begin
        // Carry kept so loops can count in multi-byte sums
        ccr_reg <= nzv_update(ccr_reg, inc_result,
          inc_src == exec_pkg::INC_OVERFLOW_OPERAND);
      end else if (wr_en && wb_adr_i == exec_pkg::CCR_OFS &&
                   wb_sel_i[0] && !busy_reg) begin
        ccr_reg <= wb_dat_i[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Accumulators and index register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_a_reg <= exec_pkg::ACC_RESET;
      acc_b_reg <= exec_pkg::ACC_RESET;
      index_x_register_reg <= exec_pkg::INDEX_RESET;
    end else if (clk_en) begin
      if (div_done) begin
        index_x_register_reg <= div_q;
        acc_a_reg <= div_r[15:8];
        acc_b_reg <= div_r[7:0];
      end else if (cmd_wr && (cmd_kind == exec_pkg::OPK_XOR ||
                              cmd_kind == exec_pkg::OPK_INC_ACC)) begin
        if (cmd_use_b) begin
          acc_b_reg <= (cmd_kind == exec_pkg::OPK_XOR) ?
                       xor_result : inc_result;
        end else begin
          acc_a_reg <= (cmd_kind == exec_pkg::OPK_XOR) ?
                       xor_result : inc_result;
        end
      end else if (wr_en && !busy_reg) begin
        if (wb_adr_i == exec_pkg::ACC_A_OFS && wb_sel_i[0]) begin
          acc_a_reg <= wb_dat_i[7:0];
        end
        if (wb_adr_i == exec_pkg::ACC_B_OFS && wb_sel_i[0]) begin
          acc_b_reg <= wb_dat_i[7:0];
        end
        if (wb_adr_i == exec_pkg::INDEX_X_OFS) begin
          if (wb_sel_i[0]) begin
            index_x_register_reg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            index_x_register_reg[15:8] <= wb_dat_i[15:8];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Memory operand and memory increment result
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      operand_reg <= 8'h00;
      mem_result_reg <= 8'h00;
    end else if (clk_en) begin
      if (wr_en && wb_adr_i == exec_pkg::OPERAND_OFS && wb_sel_i[0]) begin
        operand_reg <= wb_dat_i[7:0];
      end
      if (cmd_wr && cmd_kind == exec_pkg::OPK_INC_MEM) begin
        mem_result_reg <= inc_result;
      end
    end
  end

  // ------------------------------------------------------------
  // Divide sequencer and idle reads
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_reg <= 1'b0;
      fractional_divide_mode_reg <= 1'b0;
      idle_cnt_reg <= 6'h00;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr && (cmd_kind == exec_pkg::OPK_FRACTIONAL_DIVIDE ||
                     cmd_kind == exec_pkg::OPK_INTEGER_DIVIDE)) begin
        busy_reg <= 1'b1;
        fractional_divide_mode_reg <= (cmd_kind == exec_pkg::OPK_FRACTIONAL_DIVIDE);
        idle_cnt_reg <= exec_pkg::DIV_IDLE_CYCLES;
        mem_addr <= exec_pkg::IDLE_READ_ADDR;
        mem_rd <= 1'b1;
      end else if (div_done) begin
        busy_reg <= 1'b0;
        idle_cnt_reg <= 6'h00;
        mem_addr <= 16'h0000;
        mem_rd <= 1'b0;
      end else if (busy_reg) begin
        idle_cnt_reg <= idle_cnt_reg - 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Illegal command flag, write one to clear, set wins
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      illegal_reg <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr && cmd_kind == exec_pkg::OPK_NONE) begin
        illegal_reg <= 1'b1;
      end else if (wr_en && wb_adr_i == exec_pkg::STATUS_OFS &&
                   wb_sel_i[0] && wb_dat_i[exec_pkg::STATUS_ILLEGAL_BIT]) begin
        illegal_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Bus answer, one wait state, unmapped reads zero
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg <= bus_req;
      rdata_reg <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          exec_pkg::ACC_A_OFS: rdata_reg[7:0] <= acc_a_reg;
          exec_pkg::ACC_B_OFS: rdata_reg[7:0] <= acc_b_reg;
          exec_pkg::INDEX_X_OFS: rdata_reg[15:0] <= index_x_register_reg;
          exec_pkg::CCR_OFS: rdata_reg[7:0] <= ccr_reg;
          exec_pkg::OPERAND_OFS: rdata_reg[7:0] <= operand_reg;
          exec_pkg::STATUS_OFS: begin
            rdata_reg[exec_pkg::STATUS_BUSY_BIT] <= busy_reg;
            rdata_reg[exec_pkg::STATUS_ILLEGAL_BIT] <= illegal_reg;
          end
          exec_pkg::MEM_RESULT_OFS: rdata_reg[7:0] <= mem_result_reg;
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : xor_divide_increment_exec

// ---- sim/mem_bus_model.sv ----
// Core memory bus partner that watches the divide idle-read bursts
`timescale 1ns/100ps
module mem_bus_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Core memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  // Observations for the bench
  output logic [7:0] last_burst,
  output logic bad_addr
);
  // ------------------------------------------------------------
  // Burst length and address watch
  // ------------------------------------------------------------
  logic [7:0] run_reg;
  // Burst length latched once the reads stop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      run_reg <= 8'h00;
      last_burst <= 8'h00;
    end else if (mem_rd) begin
      run_reg <= run_reg + 8'h01;
    end else if (run_reg != 8'h00) begin
      last_burst <= run_reg;
      run_reg <= 8'h00;
    end
  end
  // Sticky, so one stray address is never lost between polls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bad_addr <= 1'b0;
    end else if (mem_rd && mem_addr != 16'hffff) begin
      bad_addr <= 1'b1;
    end
  end
endmodule : mem_bus_model

// ---- sim/exec_assertions.sv ----
// Port checker for the execution datapath
`timescale 1ns/100ps
module exec_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Idle reads
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Idle-read run counter
  // ------------------------------------------------------------
  logic [7:0] run_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || !mem_rd) begin
      run_reg <= 8'h00;
    end else begin
      run_reg <= run_reg + 8'h01;
    end
  end
  // ------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence s_div_cmd;
    s_take ##0 (wb_we_i && wb_sel_i[0] && !mem_rd &&
      wb_adr_i == exec_pkg::COMMAND_OFS && wb_dat_i[15:8] == 8'h00 &&
      (wb_dat_i[7:0] == 8'h03 || wb_dat_i[7:0] == 8'h02));
  endsequence
  property p_ack_pulse;
    wb_ack_o && clk_en |=> !wb_ack_o;
  endproperty
  property p_ack_resp;
    s_take |=> wb_ack_o;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  property p_addr_idle;
    !mem_rd |-> mem_addr == 16'h0000;
  endproperty
  property p_addr_busy;
    mem_rd |-> mem_addr == 16'hffff;
  endproperty
  property p_div_start;
    s_div_cmd |=> mem_rd;
  endproperty
  property p_div_len;
    $fell(mem_rd) |-> run_reg == 8'h27;
  endproperty
  property p_div_max;
    mem_rd |-> run_reg < 8'h27;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
  a_addr_idle: assert property (p_addr_idle)
    else $error("address not zero while idle");
  a_addr_busy: assert property (p_addr_busy)
    else $error("idle read not at top address");
  a_div_start: assert property (p_div_start)
    else $error("divide did not start idle reads");
  a_div_len: assert property (p_div_len)
    else $error("idle read burst not 39 cycles");
  a_div_max: assert property (p_div_max)
    else $error("idle read burst too long");
endmodule : exec_checker

bind xor_divide_increment_exec exec_checker exec_checker_inst (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_addr(mem_addr), .mem_rd(mem_rd)
);

// ---- sim/testbench.sv ----
// Self-checking bench for the execution datapath
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h3;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] last_burst;
  logic bad_addr;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  xor_divide_increment_exec xor_divide_increment_exec_inst (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .mem_addr(mem_addr), .mem_rd(mem_rd));
  mem_bus_model mem_bus_model_inst (
    .sys_clk(sys_clk), .reset(reset), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .last_burst(last_burst), .bad_addr(bad_addr));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Holds the request until ack is sampled, then releases it
  task automatic bus(input logic we, input logic [7:0] adr,
    input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    check(32'(wb_ack), 32'h0000_0001);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] tmp;
    bus(1'b1, adr, dat, tmp);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, adr, 32'h0000_0000, v);
    check(v, exp);
  endtask : rd_chk
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_xor();
    logic [15:0] ops [10];
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] ea;
    logic [7:0] eb;
    ops = '{16'h0088, 16'h0098, 16'h00b8, 16'h00a8, 16'h18a8,
      16'h00c8, 16'h00d8, 16'h00f8, 16'h00e8, 16'h18e8};
    for (int i = 0; i < 10; i++) begin
      v = 8'h5a ^ 8'(i * 17);
      r = (ops[i][6] ? 8'hc3 : 8'h5a) ^ v;
      ea = ops[i][6] ? 8'h5a : r;
      eb = ops[i][6] ? r : 8'hc3;
      wr(exec_pkg::ACC_A_OFS, 32'h0000_005a);
      wr(exec_pkg::ACC_B_OFS, 32'h0000_00c3);
      wr(exec_pkg::CCR_OFS, 32'h0000_0003);
      wr(exec_pkg::OPERAND_OFS, 32'(v));
      wr(exec_pkg::COMMAND_OFS, 32'(ops[i]));
      rd_chk(exec_pkg::ACC_A_OFS, 32'(ea));
      rd_chk(exec_pkg::ACC_B_OFS, 32'(eb));
      rd_chk(exec_pkg::CCR_OFS, 32'({r[7], r == 8'h00, 2'b01}));
    end
  endtask : t_xor
  task automatic t_inc();
    logic [15:0] ops [5];
    logic [7:0] vals [3];
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] ea;
    logic [7:0] eb;
    ops = '{16'h004c, 16'h005c, 16'h007c, 16'h006c, 16'h186c};
    vals = '{8'h7f, 8'hff, 8'h00};
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 3; j++) begin
        v = vals[j];
        r = v + 8'h01;
        ea = ops[i] == 16'h004c ? r : v;
        eb = ops[i] == 16'h005c ? r : v;
        wr(exec_pkg::ACC_A_OFS, 32'(v));
        wr(exec_pkg::ACC_B_OFS, 32'(v));
        wr(exec_pkg::CCR_OFS, 32'h0000_0001);
        wr(exec_pkg::OPERAND_OFS, 32'(v));
        wr(exec_pkg::COMMAND_OFS, 32'(ops[i]));
        rd_chk(exec_pkg::ACC_A_OFS, 32'(ea));
        rd_chk(exec_pkg::ACC_B_OFS, 32'(eb));
        if (ops[i][5]) begin
          rd_chk(exec_pkg::MEM_RESULT_OFS, 32'(r));
        end
        rd_chk(exec_pkg::CCR_OFS,
          32'({r[7], r == 8'h00, v == 8'h7f, 1'b1}));
      end
    end
  endtask : t_inc
  // Also writes ACC_A while busy; the remainder must win
  task automatic t_div();
    logic [39:0] cs [8];
    logic [15:0] d;
    logic [15:0] x;
    logic [15:0] q;
    logic [15:0] rm;
    logic [31:0] num;
    logic [31:0] s;
    logic v;
    logic c;
    int n;
    cs = '{40'h03_1000_4000, 40'h03_1234_8765, 40'h03_0005_0003,
      40'h03_0003_0000, 40'h03_0000_0005, 40'h02_0064_0007,
      40'h02_0005_0000, 40'h02_0003_0005};
    for (int i = 0; i < 8; i++) begin
      d = cs[i][31:16];
      x = cs[i][15:0];
      num = cs[i][32] ? {d, 16'h0000} : 32'(d);
      c = x == 16'h0000;
      v = cs[i][32] && x <= d;
      q = (c || v) ? 16'hffff : 16'(num / 32'(x));
      rm = (c || v) ? 16'h0000 : 16'(num % 32'(x));
      wr(exec_pkg::ACC_A_OFS, 32'(d[15:8]));
      wr(exec_pkg::ACC_B_OFS, 32'(d[7:0]));
      wr(exec_pkg::INDEX_X_OFS, 32'(x));
      wr(exec_pkg::CCR_OFS, 32'h0000_00fa);
      wr(exec_pkg::COMMAND_OFS, 32'(cs[i][39:32]));
      wr(exec_pkg::ACC_A_OFS, 32'h0000_00ee);
      n = 0;
      do begin
        bus(1'b0, exec_pkg::STATUS_OFS, 32'h0000_0000, s);
        n++;
      end while (s[0] !== 1'b0 && n < 40);
      check(32'(last_burst), 32'h0000_0027);
      rd_chk(exec_pkg::INDEX_X_OFS, 32'(q));
      if (!(c || v)) begin
        rd_chk(exec_pkg::ACC_A_OFS, 32'(rm[15:8]));
        rd_chk(exec_pkg::ACC_B_OFS, 32'(rm[7:0]));
      end
      rd_chk(exec_pkg::CCR_OFS,
        32'({5'b11111, q == 16'h0000, v, c}));
    end
  endtask : t_div
  task automatic t_bad();
    wr(exec_pkg::ACC_A_OFS, 32'h0000_0011);
    wr(exec_pkg::COMMAND_OFS, 32'h0000_1988);
    rd_chk(exec_pkg::STATUS_OFS, 32'h0000_0002);
    rd_chk(exec_pkg::ACC_A_OFS, 32'h0000_0011);
    wr(exec_pkg::STATUS_OFS, 32'h0000_0002);
    rd_chk(exec_pkg::STATUS_OFS, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
  endtask : t_bad
  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(exec_pkg::CCR_OFS, 32'h0000_0000);
    t_xor();
    t_inc();
    t_div();
    t_bad();
    check(32'(bad_addr), 32'h0000_0000);
    give_verdict();
  end
endmodule : testbench
